//--- pkg/pmw_pkg.sv
// Purpose: Constants and types for the power mode and wake-up control block
// Assumes: 8-bit special function register port with page select
// Notes:   Offsets, pages and field positions are defined here; the bench and properties also use literal values
package pmw_pkg;
	localparam logic [7:0] PMW_ADDR_WAKE_MODE = 8'hb5;
	localparam logic [7:0] PMW_ADDR_PWR_CTRL  = 8'h87;
	localparam logic [3:0] PMW_PAGE_WAKE      = 4'h0;
	localparam logic [3:0] PMW_PAGE_MODE      = 4'hf;

	localparam int PMW_WC_SLEEP   = 7;
	localparam int PMW_WC_SUSPEND = 6;
	localparam int PMW_WC_CLEAR   = 5;
	localparam int PMW_WC_RSTWAKE = 4;
	localparam int PMW_WC_SRC_HI  = 3;

	localparam int PMW_MD_RTC_OE  = 7;
	localparam int PMW_MD_WAKE_OE = 6;
	localparam int PMW_MD_MON_OFF = 5;

	localparam int PMW_PC_GF_LO   = 2;
	localparam int PMW_PC_STOP    = 1;
	localparam int PMW_PC_IDLE    = 0;

	localparam int PMW_NSRC       = 4;
	localparam int PMW_GF_W       = 6;

	localparam logic [7:0] PMW_RESET_BYTE = 8'h00;
	localparam logic [1:0] PMW_FLAG_HOLD  = 2'h2;

	typedef enum logic [1:0] {
		PMW_RUN,
		PMW_SUSPEND,
		PMW_SLEEP
	} pmw_mode_e;

	// Wake sources: [3] osc fail, [2] alarm, [1] port match, [0] comparator rise
	typedef struct packed {
		logic rtc_osc_fail_wake;
		logic rtc_alarm_wake;
		logic port_match_wake;
		logic comparator_wake;
	} pmw_src_s;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [3:0] page;
		logic [7:0] wdata;
	} pmw_sfr_s;
endpackage : pmw_pkg

//--- src/pmw_sync.sv
// Purpose: Two-flop synchroniser for a vector of level inputs
// Assumes: Inputs asynchronous to clk_i
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
module pmw_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	input  wire logic [W-1:0] rst_val_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : pmw_sync

//--- src/pmw_power_unit.sv
// Purpose: Power mode selection, wake-up sources and flags, mode register
// Assumes: Single-cycle register strobes from the core on clk_i
// Notes:   Event inputs are asynchronous levels and are synchronised here
`timescale 1ns/10ps
module pmw_power_unit
	import pmw_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire pmw_pkg::pmw_sfr_s     sfr_i,
	output logic      [7:0]            rdata_o,
	input  wire pmw_pkg::pmw_src_s     event_i,
	input  wire logic                  reset_pin_n_i,
	input  wire logic                  rtc_clk_i,
	output logic                       rtc_buf_o,
	output logic                       rtc_buf_oe_o,
	output logic                       wake_req_o,
	output logic                       wake_req_oe_o,
	output logic                       battery_monitor_off_o,
	output logic                       por_request_o,
	output logic                       lp_osc_keep_o,
	output logic                       suspend_o,
	output logic                       sleep_o,
	output logic                       stop_o,
	output logic                       idle_o
);
	import pmw_pkg::*;

	pmw_mode_e              mode;
	pmw_src_s               ena;
	pmw_src_s               flag;
	logic                   rst_flag;
	logic                   rtc_buffer_out_en;
	logic                   wake_request_out_en;
	logic                   battery_monitor_off;
	logic [PMW_GF_W-1:0]    general_flags;
	logic [1:0]             hold_cnt;
	logic [PMW_NSRC+1:0]    sync_q;
	logic [PMW_NSRC-1:0]    ev_s;
	logic                   pin_s;
	logic                   rtc_s;
	logic [PMW_NSRC-1:0]    ev_d;
	logic                   pin_d;
	logic [PMW_NSRC-1:0]    ev_hit;
	logic                   pin_fall;
	logic                   any_flag;
	logic                   wr_wake;
	logic                   wr_mode;
	logic                   wr_pctl;
	logic                   wake_now;
	logic                   hold;

	pmw_sync #(
		.W (PMW_NSRC + 2)
	) u_sync (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.d_i       ({rtc_clk_i, reset_pin_n_i, event_i}),
		.rst_val_i ('0),
		.q_o       (sync_q)
	);

	assign ev_s  = sync_q[PMW_NSRC-1:0];
	assign pin_s = sync_q[PMW_NSRC];
	assign rtc_s = sync_q[PMW_NSRC+1];

	// Synchroniser resets low, so history starts low: no false fall after reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ev_d  <= '0;
			pin_d <= 1'b0;
		end else begin
			ev_d  <= ev_s;
			pin_d <= pin_s;
		end
	end

	assign ev_hit   = ev_s & ~ev_d;
	assign pin_fall = pin_d & ~pin_s;

	assign wr_wake = sfr_i.wr && sfr_i.addr == PMW_ADDR_WAKE_MODE
		&& sfr_i.page == PMW_PAGE_WAKE;
	assign wr_mode = sfr_i.wr && sfr_i.addr == PMW_ADDR_WAKE_MODE
		&& sfr_i.page == PMW_PAGE_MODE;
	assign wr_pctl = sfr_i.wr && sfr_i.addr == PMW_ADDR_PWR_CTRL;

	assign any_flag = (|flag) | rst_flag;
	assign hold     = hold_cnt != 2'h0;
	assign wake_now = (|(ev_hit & ena)) | pin_fall;

	// Power mode; a command write while a flag is up is ignored
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode <= PMW_RUN;
		end else begin
			case (mode)
				PMW_RUN: begin
					if (wr_wake && !any_flag) begin
						if (sfr_i.wdata[PMW_WC_SLEEP]) begin
							mode <= PMW_SLEEP;
						end else if (sfr_i.wdata[PMW_WC_SUSPEND]) begin
							mode <= PMW_SUSPEND;
						end
					end
				end
				PMW_SUSPEND, PMW_SLEEP: begin
					if (wake_now) begin
						mode <= PMW_RUN;
					end
				end
				default: mode <= PMW_RUN;
			endcase
		end
	end

	// Blanking after leaving suspend
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_cnt <= 2'h0;
		end else if (mode == PMW_SUSPEND && wake_now) begin
			hold_cnt <= PMW_FLAG_HOLD;
		end else if (hold) begin
			hold_cnt <= hold_cnt - 2'h1;
		end
	end

	// Enables written alongside each command
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ena <= '0;
		end else if (wr_wake) begin
			ena <= pmw_src_s'(sfr_i.wdata[PMW_WC_SRC_HI:0]);
		end
	end

	// Flags set on any event; set beats clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag     <= '0;
			rst_flag <= 1'b0;
		end else begin
			if (wr_wake && sfr_i.wdata[PMW_WC_CLEAR]) begin
				flag     <= pmw_src_s'(ev_hit);
				rst_flag <= pin_fall;
			end else begin
				flag     <= flag | pmw_src_s'(ev_hit);
				rst_flag <= rst_flag | pin_fall;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rtc_buffer_out_en   <= 1'b0;
			wake_request_out_en <= 1'b0;
			battery_monitor_off <= 1'b0;
			por_request_o       <= 1'b0;
		end else begin
			por_request_o <= wr_mode && battery_monitor_off
				&& !sfr_i.wdata[PMW_MD_MON_OFF];
			if (wr_mode) begin
				rtc_buffer_out_en   <= sfr_i.wdata[PMW_MD_RTC_OE];
				wake_request_out_en <= sfr_i.wdata[PMW_MD_WAKE_OE];
				battery_monitor_off <= sfr_i.wdata[PMW_MD_MON_OFF];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			general_flags <= '0;
			stop_o        <= 1'b0;
			idle_o        <= 1'b0;
		end else begin
			stop_o <= wr_pctl && sfr_i.wdata[PMW_PC_STOP];
			idle_o <= wr_pctl && sfr_i.wdata[PMW_PC_IDLE];
			if (wr_pctl) begin
				general_flags <= sfr_i.wdata[7:PMW_PC_GF_LO];
			end
		end
	end

	// Pins and levels, all registered
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rtc_buf_o             <= 1'b0;
			rtc_buf_oe_o          <= 1'b0;
			wake_req_o            <= 1'b0;
			wake_req_oe_o         <= 1'b0;
			battery_monitor_off_o <= 1'b0;
			lp_osc_keep_o         <= 1'b1;
			suspend_o             <= 1'b0;
			sleep_o               <= 1'b0;
		end else begin
			rtc_buf_o             <= rtc_buffer_out_en & rtc_s;
			rtc_buf_oe_o          <= rtc_buffer_out_en;
			wake_req_o            <= mode != PMW_SLEEP;
			wake_req_oe_o         <= wake_request_out_en;
			battery_monitor_off_o <= battery_monitor_off;
			lp_osc_keep_o         <= any_flag || mode == PMW_RUN;
			suspend_o             <= mode == PMW_SUSPEND;
			sleep_o               <= mode == PMW_SLEEP;
		end
	end

	// Command bits and unused mode bits read zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= PMW_RESET_BYTE;
		end else if (sfr_i.rd) begin
			if (sfr_i.addr == PMW_ADDR_PWR_CTRL) begin
				rdata_o <= {general_flags, 2'b00};
			end else if (sfr_i.addr == PMW_ADDR_WAKE_MODE && sfr_i.page == PMW_PAGE_WAKE) begin
				rdata_o <= hold ? PMW_RESET_BYTE
					: {3'b000, rst_flag, flag};
			end else if (sfr_i.addr == PMW_ADDR_WAKE_MODE && sfr_i.page == PMW_PAGE_MODE) begin
				rdata_o <= {rtc_buffer_out_en, wake_request_out_en,
					battery_monitor_off, 5'b00000};
			end else begin
				rdata_o <= PMW_RESET_BYTE;
			end
		end
	end
endmodule : pmw_power_unit

//--- sim/pmw_power_unit_properties.sv
// Purpose: Port timing checks for the power unit
// Assumes: One clock domain, bound to pmw_power_unit
// Notes:   Strobes decoded here from the register port
`timescale 1ns/10ps
module pmw_power_unit_props
	import pmw_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire pmw_pkg::pmw_sfr_s sfr_i,
	input wire logic [7:0]        rdata_o,
	input wire logic              reset_pin_n_i,
	input wire logic              rtc_buf_oe_o,
	input wire logic              wake_req_o,
	input wire logic              wake_req_oe_o,
	input wire logic              battery_monitor_off_o,
	input wire logic              por_request_o,
	input wire logic              suspend_o,
	input wire logic              sleep_o,
	input wire logic              stop_o,
	input wire logic              idle_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic mwr, mrd, pwr, prd, unm;
	assign mwr = sfr_i.wr && sfr_i.addr == PMW_ADDR_WAKE_MODE && sfr_i.page == PMW_PAGE_MODE;
	assign mrd = sfr_i.rd && sfr_i.addr == PMW_ADDR_WAKE_MODE && sfr_i.page == PMW_PAGE_MODE;
	assign pwr = sfr_i.wr && sfr_i.addr == PMW_ADDR_PWR_CTRL;
	assign prd = sfr_i.rd && sfr_i.addr == PMW_ADDR_PWR_CTRL;
	// Anything but the three mapped places
	assign unm = sfr_i.rd && !prd && !(sfr_i.addr == PMW_ADDR_WAKE_MODE
		&& (sfr_i.page == PMW_PAGE_WAKE || sfr_i.page == PMW_PAGE_MODE));

	AST_RTC_OE: assert property (
		$changed(rtc_buf_oe_o) |-> $past(mwr) || $past(mwr, 2)) else $error("buffered clock enable moved alone");
	AST_WAKE_OE: assert property (
		mwr ##1 !mwr |=> wake_req_oe_o == $past(sfr_i.wdata[PMW_MD_WAKE_OE], 2)) else $error("wake output enable wrong");
	AST_MON_OFF: assert property (
		$rose(battery_monitor_off_o) |-> $past(mwr && sfr_i.wdata[5]) || $past(mwr && sfr_i.wdata[5], 2)) else $error("monitor off without write");
	AST_POR: assert property (
		por_request_o |-> ($past(mwr && !sfr_i.wdata[5]) || $past(mwr && !sfr_i.wdata[5], 2)) ##1 !por_request_o) else $error("bad power-on request");
	AST_STOP: assert property (
		stop_o |-> $past(pwr && sfr_i.wdata[PMW_PC_STOP])) else $error("stop without command");
	AST_IDLE: assert property (
		pwr && sfr_i.wdata[PMW_PC_IDLE] |=> idle_o ##1 !idle_o) else $error("idle pulse wrong");
	AST_MODE_RD: assert property (
		mrd |=> rdata_o[4:0] == 5'h00) else $error("unused mode bits not zero");
	AST_UNMAPPED: assert property (
		unm |=> rdata_o == 8'h00) else $error("unmapped read not zero");
	AST_PC_RD: assert property (
		prd |=> rdata_o[1:0] == 2'h0) else $error("command bits readable");
	AST_WAKE_REQ: assert property (
		$past(rst_n_i) |-> wake_req_o == !sleep_o) else $error("wake request not inverse of sleep");
	AST_PIN_WAKE: assert property (
		$fell(reset_pin_n_i) && sleep_o |-> ##[1:6] !sleep_o) else $error("reset pin did not wake");

	cover property ($rose(sleep_o));
	cover property ($fell(suspend_o));
	cover property (por_request_o);
endmodule : pmw_power_unit_props

//--- sim/testbench.sv
// Purpose: Self-checking bench for the power unit
// Assumes: Notes timing, 40 ns clock
// Notes:   Reads are checked from a queue by a monitor
`timescale 1ns/10ps
module testbench;
	import pmw_pkg::*;
	logic      clk_i, rst_n_i, reset_pin_n_i, rtc_clk_i, rd_q;
	pmw_sfr_s  sfr_i;
	pmw_src_s  event_i;
	logic [7:0] rdata_o, d;
	logic      rtc_buf_o, rtc_buf_oe_o, wake_req_o, wake_req_oe_o, battery_monitor_off_o;
	logic      por_request_o, lp_osc_keep_o, suspend_o, sleep_o, stop_o, idle_o;
	logic [7:0] expq[$];
	int        errors, checks_done, por_cnt, i;
	int unsigned seed;
	wire logic [7:0] st = {2'h0, stop_o, idle_o, suspend_o, sleep_o, wake_req_o, lp_osc_keep_o};
	wire logic [7:0] mo = {5'h0, rtc_buf_oe_o, wake_req_oe_o, battery_monitor_off_o};

	pmw_power_unit dut (.*);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task bus(input logic w, r, input logic [7:0] a, input logic [3:0] p, input logic [7:0] dt);
		@(posedge clk_i);
		#1;
		sfr_i = '{w, r, a, p, dt};
		rtc_clk_i = 1'($urandom);
	endtask : bus

	task idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 8'h00, 4'h0, 8'h00);
	endtask : idle

	task rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] exp);
		expq.push_back(exp);
		bus(1'b0, 1'b1, a, p, 8'h00);
	endtask : rd

	task summarize;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// Rdata is valid the cycle after the read edge
	always @(posedge clk_i) begin
		if (rd_q) begin
			check(rdata_o, expq.pop_front());
		end
		if (por_request_o === 1'b1) begin
			por_cnt++;
		end
		rd_q <= sfr_i.rd;
	end

	initial begin
		#100000;
		errors++;
		summarize();
	end

	initial begin
		sfr_i = '0;
		event_i = '0;
		reset_pin_n_i = 1'b1;
		rtc_clk_i = 1'b0;
		rst_n_i = 1'b0;
		rd_q = 1'b0;
		seed = $urandom(5);
		repeat (20) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		idle(4);
		check(st, 8'h03);
		rd(8'h87, 4'h5, 8'h00);
		rd(8'hb5, 4'hf, 8'h00);
		rd(8'hb5, 4'h3, 8'h00);
		rd(8'h42, 4'h0, 8'h00);
		for (i = 0; i < 4; i++) begin
			d = 8'($urandom) & 8'hfc;
			bus(1'b1, 1'b0, 8'h87, 4'($urandom), d);
			rd(8'h87, 4'($urandom), d);
		end
		for (i = 0; i < 2; i++) begin
			bus(1'b1, 1'b0, 8'h87, 4'h0, 8'(1 << i));
			idle(1);
			check(st, 8'h03 | 8'(16 << i));
		end
		bus(1'b1, 1'b0, 8'hb5, 4'hf, 8'($urandom) | 8'he0);
		rd(8'hb5, 4'hf, 8'he0);
		idle(2);
		check(mo, 8'h07);
		bus(1'b1, 1'b0, 8'hb5, 4'hf, 8'h1f);
		idle(3);
		check(mo, 8'h00);
		check(8'(por_cnt), 8'h01);
		for (i = 0; i < 5; i++) begin
			if (i < 4) event_i = pmw_src_s'(4'(1 << i));
			else reset_pin_n_i = 1'b0;
			idle(5);
			rd(8'hb5, 4'h0, 8'(1 << i));
			event_i = '0;
			reset_pin_n_i = 1'b1;
			bus(1'b1, 1'b0, 8'hb5, 4'h0, 8'h20);
			rd(8'hb5, 4'h0, 8'h00);
		end
		bus(1'b1, 1'b0, 8'hb5, 4'h0, 8'h84);
		idle(12);
		check(st, 8'h04);
		event_i = pmw_src_s'(4'h4);
		idle(6);
		check(st, 8'h03);
		bus(1'b1, 1'b0, 8'hb5, 4'h0, 8'h84);
		idle(3);
		check(st, 8'h03);
		event_i = '0;
		bus(1'b1, 1'b0, 8'hb5, 4'h0, 8'h20);
		bus(1'b1, 1'b0, 8'hb5, 4'h0, 8'h42);
		idle(3);
		check(st, 8'h0a);
		event_i = pmw_src_s'(4'h4);
		idle(6);
		check(st, 8'h0b);
		event_i = pmw_src_s'(4'h6);
		idle(6);
		check(st, 8'h03);
		rd(8'hb5, 4'h0, 8'h06);
		event_i = '0;
		bus(1'b1, 1'b0, 8'hb5, 4'h0, 8'h20);
		bus(1'b1, 1'b0, 8'hb5, 4'h0, 8'h80);
		idle(3);
		check(st, 8'h04);
		reset_pin_n_i = 1'b0;
		idle(6);
		check(st, 8'h03);
		rd(8'hb5, 4'h0, 8'h10);
		reset_pin_n_i = 1'b1;
		idle(3);
		summarize();
	end
endmodule : testbench

bind pmw_power_unit pmw_power_unit_props u_props (.*);
